// ### verilog/tsb_pkg.sv
/*
  Constants and carrier types for the telegram status byte encoder.
  Assumes a single 20 MHz system clock. All times are derived from that rate.
*/
package tsb_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned TSB_CLK_HZ       = 20_000_000;
  localparam int unsigned TSB_TICK_TIME_S  = 1;
  localparam int unsigned TSB_SEC_CYCLES   = TSB_CLK_HZ * TSB_TICK_TIME_S;
  localparam logic [7:0]  TSB_STALE_TIME_S = 8'h0A;  // No-new-value limit, 10 s.
  localparam logic [7:0]  TSB_AVG_LONG_S   = 8'h0A;  // Long averaging from 10 s.
  localparam logic [7:0]  TSB_STATIC_S     = 8'h3C;  // Persistence limit, 1 min.

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int unsigned TSB_OP_OCC_LSB  = 1;
  localparam int unsigned TSB_OP_OCC_MSB  = 3;
  localparam int unsigned TSB_OP_HCRIT    = 5;
  localparam int unsigned TSB_OP_HON      = 6;
  localparam int unsigned TSB_ER_GEN      = 0;
  localparam int unsigned TSB_ER_STATIC   = 1;
  localparam int unsigned TSB_CT_INVALID  = 0;
  localparam int unsigned TSB_CT_TDIF_LSB = 1;
  localparam int unsigned TSB_CT_FILL_LSB = 3;
  localparam int unsigned TSB_CT_ONE      = 6;
  localparam int unsigned TSB_CT_HON      = 7;

  // ---------------------------------------------------------------
  // Reset values and grading thresholds
  // ---------------------------------------------------------------
  localparam logic [7:0]  TSB_OP_RESET = 8'h00;
  localparam logic [7:0]  TSB_ER_RESET = 8'h00;
  localparam logic [7:0]  TSB_CT_RESET = 8'h40;  // Bit 6 of compact byte is always one.
  localparam logic [7:0]  TSB_TD_LIM0  = 8'h1F;  // 3.1 K in 0.1 K steps.
  localparam logic [7:0]  TSB_TD_LIM1  = 8'h3F;  // 6.3 K.
  localparam logic [7:0]  TSB_TD_LIM2  = 8'h4F;  // 7.9 K.
  localparam logic [15:0] TSB_PCT_FULL = 16'h0064; // 100 percent.
  localparam logic [15:0] TSB_PCT_HI   = 16'h0050; // 80 percent.
  localparam logic [15:0] TSB_PCT_MID  = 16'h0042; // 66 percent.
  localparam logic [15:0] TSB_PCT_LO   = 16'h0021; // 33 percent.
  localparam logic [15:0] TSB_OCTANTS  = 16'h0008;

  typedef struct packed {
    logic [7:0] op;       // Operating status byte.
    logic [7:0] err;      // Error status byte.
    logic [7:0] compact;  // Compact telegram status byte.
  } tsb_status_t;

endpackage : tsb_pkg

// ### verilog/tsb_fill_grader.sv
/*
  Grades averaging buffer occupancy into an eighths code and a coarse two-bit code.
  Assumes fill never exceeds capacity; capacity zero grades as the lowest class.
*/
`timescale 1ns/100ps
module tsb_fill_grader
  import tsb_pkg::*;
(
  input  wire logic [7:0] fill_i,
  input  wire logic [7:0] cap_i,
  output logic      [2:0] octant_o,
  output logic      [1:0] coarse_o
);

  logic [6:0]  above;
  logic [15:0] fill8;
  logic [15:0] fill_pct;

  assign fill8    = TSB_OCTANTS * {8'h00, fill_i};
  assign fill_pct = TSB_PCT_FULL * {8'h00, fill_i};

  // ---------------------------------------------------------------
  // Eighths: one comparator per boundary k/8, the code is their count.
  // ---------------------------------------------------------------
  for (genvar k = 1; k < 8; k++) begin : g_oct
    logic [15:0] bound;
    assign bound      = 16'(k) * {8'h00, cap_i};
    assign above[k-1] = fill8 > bound;
  end

  // Above-boundary flags are thermometer coded, so a population count is exact.
  always_comb begin
    octant_o = 3'h0;
    for (int i = 0; i < 7; i++) begin
      octant_o = octant_o + {2'h0, above[i]};
    end
  end

  // Coarse grade for the compact byte: 00 highest fill, 11 at or below 33 percent.
  always_comb begin
    if (fill_pct > TSB_PCT_HI * {8'h00, cap_i}) begin
      coarse_o = 2'h0;
    end else if (fill_pct > TSB_PCT_MID * {8'h00, cap_i}) begin
      coarse_o = 2'h1;
    end else if (fill_pct > TSB_PCT_LO * {8'h00, cap_i}) begin
      coarse_o = 2'h2;
    end else begin
      coarse_o = 2'h3;
    end
  end

endmodule : tsb_fill_grader

// ### verilog/tsb_status_encoder.sv
/*
  Telegram status byte encoder: builds operating, error and compact status bytes.
  Assumes all inputs are synchronous to clk_i and that latch_i pulses once per
  telegram assembly. The buffer capacity equals the averaging time in seconds.
*/
// Operation
// - Buffer occupancy appears as a three-bit binary value in operating bits 1 to 3.
// - Code n means the fill fraction lies above n/8 and at most (n+1)/8.
// - Operating bit 5 is one exactly while the heating switch-on criterion holds.
// - Operating bit 6 is one exactly while the heating is on.
// - Below 10 s averaging, error bit 0 sets after 10 s without a new value.
// - From 10 s averaging, error bit 0 sets when under half the slots hold values.
// - Error bit 1 sets once a malfunction has lasted longer than one minute.
// - The compact telegram carries its own separate one-byte status.
// - Compact bit 0 is zero for valid data and one for invalid data.
// - Compact bit 7 is one while the heating is on.
// - A general error (bit 0) present at assembly selects the error telegram and shows in the status.
`timescale 1ns/100ps
module tsb_status_encoder
  import tsb_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = TSB_SEC_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        new_value_i,
  input  wire logic [7:0]  avg_time_s_i,
  input  wire logic [7:0]  fill_cnt_i,
  input  wire logic        heat_crit_i,
  input  wire logic        heat_on_i,
  input  wire logic        data_valid_i,
  input  wire logic [7:0]  temp_diff_i,
  input  wire logic        latch_i,
  output tsb_status_t      status_o,
  output logic             err_tlg_o
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [24:0]  sec_cnt_q;
  logic [24:0]  sec_cnt_d;
  logic         sec_tick;
  logic [7:0]   stale_s_q;
  logic [7:0]   stale_s_d;
  logic [7:0]   static_s_q;
  logic [7:0]   static_s_d;
  logic         long_avg;
  logic         half_short;
  logic         gen_err;
  logic         static_err;
  logic [2:0]   octant;
  logic [1:0]   coarse;
  logic [1:0]   tdif_code;
  tsb_status_t  live;
  tsb_status_t  status_q;
  logic         err_tlg_q;

  // ---------------------------------------------------------------
  // One-second time base
  // ---------------------------------------------------------------

  // Free-running divider; a parameter so that simulation can shorten a second.
  assign sec_tick  = sec_cnt_q == 25'(SEC_CYCLES - 1);
  assign sec_cnt_d = sec_tick ? 25'h0000000 : sec_cnt_q + 25'h0000001;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sec_cnt_q <= 25'h0000000;
    end else begin
      sec_cnt_q <= sec_cnt_d;
    end
  end

  // ---------------------------------------------------------------
  // Malfunction monitors
  // ---------------------------------------------------------------

  // Seconds since the last new value; saturates so that it never wraps back to fine.
  always_comb begin
    if (new_value_i) begin
      stale_s_d = 8'h00;
    end else if (sec_tick && stale_s_q != 8'hFF) begin
      stale_s_d = stale_s_q + 8'h01;
    end else begin
      stale_s_d = stale_s_q;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stale_s_q <= 8'h00;
    end else begin
      stale_s_q <= stale_s_d;
    end
  end

  // Short averaging watches value age, long averaging watches slot occupancy.
  assign long_avg   = avg_time_s_i >= TSB_AVG_LONG_S;
  assign half_short = {1'b0, fill_cnt_i, 1'b0} < {2'h0, avg_time_s_i};
  assign gen_err    = long_avg ? half_short
                               : (stale_s_q >= TSB_STALE_TIME_S);

  // Persistence of the general malfunction, in whole seconds.
  always_comb begin
    if (!gen_err) begin
      static_s_d = 8'h00;
    end else if (sec_tick && static_s_q != 8'hFF) begin
      static_s_d = static_s_q + 8'h01;
    end else begin
      static_s_d = static_s_q;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      static_s_q <= 8'h00;
    end else begin
      static_s_q <= static_s_d;
    end
  end

  // Strictly longer than a minute; counted seconds have one second of grain.
  assign static_err = static_s_q > TSB_STATIC_S;

  // ---------------------------------------------------------------
  // Occupancy grading
  // ---------------------------------------------------------------
  tsb_fill_grader u_grader (
    .fill_i   (fill_cnt_i),
    .cap_i    (avg_time_s_i),
    .octant_o (octant),
    .coarse_o (coarse)
  );

  // Temperature difference between axes, 0.1 K steps, graded in four bands.
  always_comb begin
    if (temp_diff_i <= TSB_TD_LIM0) begin
      tdif_code = 2'h0;
    end else if (temp_diff_i <= TSB_TD_LIM1) begin
      tdif_code = 2'h1;
    end else if (temp_diff_i <= TSB_TD_LIM2) begin
      tdif_code = 2'h2;
    end else begin
      tdif_code = 2'h3;
    end
  end

  // ---------------------------------------------------------------
  // Live byte composition
  // ---------------------------------------------------------------

  // Start from the reset images so reserved bits keep their fixed values.
  always_comb begin
    live = '{op: TSB_OP_RESET, err: TSB_ER_RESET, compact: TSB_CT_RESET};
    live.op[TSB_OP_OCC_MSB:TSB_OP_OCC_LSB] = octant;
    live.op[TSB_OP_HCRIT]                   = heat_crit_i;
    live.op[TSB_OP_HON]                     = heat_on_i;
    live.err[TSB_ER_GEN]                    = gen_err;
    live.err[TSB_ER_STATIC]                 = static_err;
    live.compact[TSB_CT_INVALID]            = ~data_valid_i;
    live.compact[TSB_CT_TDIF_LSB +: 2]      = tdif_code;
    live.compact[TSB_CT_FILL_LSB +: 2]      = coarse;
    live.compact[TSB_CT_HON]                = heat_on_i;
  end

  // ---------------------------------------------------------------
  // Telegram snapshot
  // ---------------------------------------------------------------

  // All three bytes are caught on one edge, so a telegram never mixes two moments.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      status_q <= '{op: TSB_OP_RESET, err: TSB_ER_RESET, compact: TSB_CT_RESET};
    end else if (latch_i) begin
      status_q <= live;
    end
  end

  // Error telegram selection is held with the snapshot it belongs to.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      err_tlg_q <= 1'b0;
    end else if (latch_i) begin
      err_tlg_q <= gen_err;
    end
  end

  assign status_o  = status_q;
  assign err_tlg_o = err_tlg_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  sequence s_latch_empty;
    latch_i && fill_cnt_i == 8'h00;
  endsequence

  sequence s_latch_full;
    latch_i && fill_cnt_i == avg_time_s_i && avg_time_s_i != 8'h00;
  endsequence

  sequence s_latch_stale;
    latch_i && !long_avg && stale_s_q >= TSB_STALE_TIME_S;
  endsequence

  a_occ_empty_low:
    assert property (s_latch_empty |=> status_o.op[3:1] == 3'h0)
    else $error("Empty buffer not graded as lowest eighth.");

  a_occ_full_top:
    assert property (s_latch_full |=> status_o.op[3:1] == 3'h7)
    else $error("Full buffer not graded as highest eighth.");

  a_heat_crit_bit:
    assert property (latch_i |=> status_o.op[5] == $past(heat_crit_i))
    else $error("Heating criterion bit does not follow its source.");

  a_heat_on_bits:
    assert property (latch_i |=> status_o.op[6] == $past(heat_on_i)
                                 && status_o.compact[7] == $past(heat_on_i))
    else $error("Heating-on bits do not follow heating state.");

  a_stale_error:
    assert property (s_latch_stale |=> status_o.err[0] && err_tlg_o)
    else $error("Stale measurement did not raise general error.");

  a_half_fill_err:
    assert property (latch_i && long_avg |=> status_o.err[0] == $past(half_short))
    else $error("Occupancy error disagrees with half-fill check.");

  a_static_delay:
    assert property (latch_i && static_s_q <= TSB_STATIC_S |=> !status_o.err[1])
    else $error("Static malfunction flagged within one minute.");

  a_static_needs_gen:
    assert property (!gen_err |=> static_s_q == 8'h00 ##1 !static_err)
    else $error("Static timer kept running without general error.");

  a_valid_flag:
    assert property (latch_i |=> status_o.compact[0] != $past(data_valid_i))
    else $error("Compact data error bit has wrong sense.");

  a_reserved_fixed:
    assert property (status_o.op[0] == 1'b0 && status_o.op[4] == 1'b0
                     && status_o.op[7] == 1'b0 && status_o.err[7:2] == 6'h00
                     && status_o.compact[6:5] == 2'h2)
    else $error("Reserved status bit off its fixed value.");

  a_hold_between:
    assert property (!latch_i |=> $stable(status_o) && $stable(err_tlg_o))
    else $error("Status changed without a telegram latch.");

  a_err_tlg_pair:
    assert property (err_tlg_o == status_o.err[0])
    else $error("Error telegram selection disagrees with status byte.");

endmodule : tsb_status_encoder

// ### verif/tsb_host_model.sv
/*
  Host model: strobes telegram assembly and captures the three status bytes.
  Assumes the bench drives every other encoder input at the falling clock edge.
*/
`timescale 1ns/100ps
module tsb_host_model
  import tsb_pkg::*;
(
  input  wire logic        clk_i,
  input  wire tsb_status_t status_i,
  input  wire logic        err_tlg_i,
  output logic             latch_o
);
  // One strobe per telegram; capture one edge later so the registered bytes have landed.
  // A gap of zero lets the caller strobe back to back, a long gap models a slow host.
  task automatic snap(input int gap, output tsb_status_t s, output logic e);
    @(negedge clk_i);
    latch_o = 1'h1;
    @(negedge clk_i);
    latch_o = 1'h0;
    s = status_i;
    e = err_tlg_i;
    repeat (gap) @(negedge clk_i);
  endtask : snap

  // The strobe rests low until the first telegram.
  initial latch_o = 1'h0;
endmodule : tsb_host_model

// ### verif/tsb_status_encoder_tb_top.sv
/*
  Self-checking bench for the status byte encoder with a shortened second.
  Assumes the host model owns the assembly strobe; all else is driven here.
*/
`timescale 1ns/100ps
module tsb_status_encoder_tb_top
  import tsb_pkg::*;
;
  localparam int SEC = 20;  // Shortened second keeps the one-minute monitor brief.
  typedef struct packed {
    logic [7:0] avg;
    logic [7:0] fill;
    logic       hc;
    logic       ho;
    logic       dv;
    logic [7:0] td;
  } tsb_row_t;
  logic        clk_i, nrst, new_value, hc, ho, dv, latch, err_tlg;
  logic [7:0]  avg, fill, td;
  tsb_status_t status, s, m;
  logic        e;
  int          fail_count, samples_checked, cycles;
  tsb_row_t    rows [10] = '{
    '{8'h10, 8'h00, 1'h0, 1'h0, 1'h1, 8'h1F}, '{8'h10, 8'h02, 1'h1, 1'h0, 1'h0, 8'h20},
    '{8'h10, 8'h03, 1'h0, 1'h1, 1'h1, 8'h3F}, '{8'h10, 8'h08, 1'h1, 1'h1, 1'h0, 8'h40},
    '{8'h10, 8'h10, 1'h0, 1'h0, 1'h1, 8'h4F}, '{8'h0A, 8'h05, 1'h1, 1'h0, 1'h1, 8'h50},
    '{8'h0A, 8'h04, 1'h0, 1'h1, 1'h0, 8'h00}, '{8'hC8, 8'h85, 1'h1, 1'h1, 1'h1, 8'hFF},
    '{8'hFF, 8'hFF, 1'h0, 1'h1, 1'h0, 8'h3E}, '{8'h0A, 8'h0A, 1'h1, 1'h1, 1'h1, 8'h1E}};

  tsb_status_encoder #(.SEC_CYCLES(SEC)) tsb_status_encoder_inst (
    .clk_i(clk_i), .nrst_i(nrst), .new_value_i(new_value), .avg_time_s_i(avg),
    .fill_cnt_i(fill), .heat_crit_i(hc), .heat_on_i(ho), .data_valid_i(dv),
    .temp_diff_i(td), .latch_i(latch), .status_o(status), .err_tlg_o(err_tlg));
  tsb_host_model tsb_host_model_inst (
    .clk_i(clk_i), .status_i(status), .err_tlg_i(err_tlg), .latch_o(latch));

  // Clock and a cycle watchdog, so a hang still reaches the verdict.
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles > 100000) begin
      fail_count++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("Checked %0d samples, %0d mismatches", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test

  task automatic check(string what, logic [7:0] got, logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Reference bytes worked out from fill, capacity and flags (long averaging only).
  function automatic tsb_status_t expect_bytes(tsb_row_t r);
    tsb_status_t x;
    int f, c, oct, cr, bd;
    f = r.fill;
    c = r.avg;
    oct = 0;
    for (int k = 1; k < 8; k++) if (8 * f > k * c) oct++;
    cr = (100 * f > 80 * c) ? 0 : (100 * f > 66 * c) ? 1 : (100 * f > 33 * c) ? 2 : 3;
    bd = (r.td <= 31) ? 0 : (r.td <= 63) ? 1 : (r.td <= 79) ? 2 : 3;
    x.op = {1'h0, r.ho, r.hc, 1'h0, oct[2:0], 1'h0};
    x.err = {7'h00, 2 * f < c};
    x.compact = {r.ho, 1'h1, 1'h0, cr[1:0], bd[1:0], ~r.dv};
    return x;
  endfunction : expect_bytes

  task automatic snap_err(logic [7:0] exp);
    tsb_host_model_inst.snap(0, s, e);
    check("err", s.err, exp);
    check("err_tlg", {7'h00, e}, {7'h00, exp[0]});
  endtask : snap_err

  initial begin
    clk_i = 1'h0;
    nrst = 1'h0;
    {new_value, hc, ho, dv, avg, fill, td} = '0;
    repeat (6) @(negedge clk_i);
    check("op_rst", status.op, 8'h00);
    check("compact_rst", status.compact, 8'h40);
    nrst = 1'h1;
    $display("Test reset done");
    // Table of ordinary snapshots, gap alternates to mix fast and slow hosts.
    foreach (rows[i]) begin
      @(negedge clk_i);
      {avg, fill, hc, ho, dv, td} = rows[i];
      tsb_host_model_inst.snap(i % 2, s, e);
      m = expect_bytes(rows[i]);
      check("op", s.op, m.op);
      check("err", s.err, m.err);
      check("compact", s.compact, m.compact);
      check("err_tlg", {7'h00, e}, {7'h00, m.err[0]});
    end
    $display("Test table done");
    // Inputs move without a strobe: the bytes must hold.
    ho = ~ho;
    dv = ~dv;
    repeat (3) @(negedge clk_i);
    check("hold", status.compact, s.compact);
    $display("Test hold done");
    // Short averaging: stale data, then a lasting malfunction, then recovery.
    avg = 8'h05;
    fill = 8'h05;
    new_value = 1'h1;
    repeat (2) @(negedge clk_i);
    new_value = 1'h0;
    repeat (8 * SEC) @(negedge clk_i);
    snap_err(8'h00);
    repeat (3 * SEC) @(negedge clk_i);
    snap_err(8'h01);
    repeat (56 * SEC) @(negedge clk_i);
    snap_err(8'h01);
    repeat (6 * SEC) @(negedge clk_i);
    snap_err(8'h03);
    new_value = 1'h1;
    // The minute monitor clears one edge after the general error does.
    // The first telegram after recovery therefore still carries the static flag.
    snap_err(8'h02);
    snap_err(8'h00);
    new_value = 1'h0;
    $display("Test stale done");
    // Reset in mid-run acts without a clock edge.
    #5 nrst = 1'h0;
    #1;
    check("err_rst", status.err, 8'h00);
    check("compact_rst", status.compact, 8'h40);
    // Release again: the first telegram after it must carry fresh, error-free bytes.
    @(negedge clk_i);
    nrst = 1'h1;
    snap_err(8'h00);
    check("op_rel", s.op, 8'h2E);
    $display("Test midreset done");
    finish_test();
  end
endmodule : tsb_status_encoder_tb_top
